// ==== design/ssgc_pkg.sv ====
// package for the system status and general control register pair
// assumes a two-wire serial front end that turns frames into byte register accesses
package ssgc_pkg;

    // ----------------------------------------------------------------
    // register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SYSTEM_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h01;
    localparam logic [7:0] STATUS_RESET        = 8'h81;
    localparam logic [7:0] GENCFG_RESET        = 8'h00;

    // ----------------------------------------------------------------
    // system_status field positions
    // ----------------------------------------------------------------
    localparam int ST_FIXED_ONE = 7;
    localparam int ST_SEQ       = 6;
    localparam int ST_HS        = 5;
    localparam int ST_AVG       = 3;
    localparam int ST_FUSE      = 2;
    localparam int ST_CRCERR    = 1;
    localparam int ST_BOR       = 0;

    // ----------------------------------------------------------------
    // general_config field positions
    // ----------------------------------------------------------------
    localparam int GC_CRC_EN = 6;
    localparam int GC_STATS  = 5;
    localparam int GC_WCMP   = 4;
    localparam int GC_CONV   = 3;
    localparam int GC_FORCE  = 2;
    localparam int GC_CAL    = 1;
    localparam int GC_SRST   = 0;

    // ----------------------------------------------------------------
    // sticky flags: index 0 averaging, 1 checksum error, 2 brown-out
    // ----------------------------------------------------------------
    localparam int         NUM_FLAGS  = 3;
    localparam logic [2:0] FLAG_RESET = 3'h4;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 4;
    localparam int         SRST_TIME_NS  = 16;
    localparam int         SRST_CYCLES_I = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SRST_LAST     = 3'(SRST_CYCLES_I - 1);

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSGC_IDLE = 2'b00,
        SSGC_SRST = 2'b01,
        SSGC_DONE = 2'b11
    } ssgc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssgc_reg_req_t;

    typedef struct packed {
        logic seq_running;
        logic hs_mode;
        logic avg_ready;
        logic crc_mismatch;
        logic brownout;
        logic cal_done;
        logic ninth_fall;
        logic conv_done;
    } ssgc_evt_t;

endpackage

// ==== design/ssgc_regs.sv ====
// system status and general control registers with their side effects
// assumes reg_req comes one cycle per byte access from the serial front end
`timescale 1ns/100ps
`default_nettype none

// Function
// (R1) status bit 6 reads 1 while a channel sequence runs, else 0.
// (R2) status bit 5 reads 1 while bus is in high-speed mode; read-only.
// (R3) averaging flag set when averaged result ready; host clears by writing 1.
// (R4) config check flag captured at load; re-evaluated only after software reset.
// (R5) incoming checksum error flag set on mismatch; host clears by writing 1.
// (R6) while checksum error set, writes outside status and control are rejected.
// (R7) brown-out flag resets to 1, set on events, cleared by writing 1.
// (R8) checksum enable appends and checks checksums; disabled when 0.
// (R9) statistics enable clears then updates statistics; no update when 0.
// (R10) window comparator enabled by 1, reset and disabled by 0.
// (R11) normal mode: convert on ninth falling edge, hold clock low until done.
// (R12) writing conversion start starts conversion without stretching; reads as 0.
// (R13) channel override forces every channel to analog input.
// (R14) calibration bit runs offset calibration, clears itself on completion.
// (R15) software reset restores defaults, then clears itself and sets brown-out.
// (R16) reserved bits ignore writes, read 0; status top bit reads 1.
// (R17) continue-on-error plus checksum error forces analog and pauses sequencing.
// (R18) writing 0 to sticky flags or read-only bits changes nothing.
module ssgc_regs (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire ssgc_pkg::ssgc_reg_req_t reg_req,
    input  wire ssgc_pkg::ssgc_evt_t     evt,
    input  wire logic               cfg_check_fail,
    input  wire logic               continue_on_error,
    output logic [7:0]              reg_rdata_ff,
    output logic                    other_wr_allow,
    output logic                    crc_enable,
    output logic                    stats_enable,
    output logic                    stats_clear_ff,
    output logic                    window_comparator_enable,
    output logic                    window_comparator_reset,
    output logic                    conv_start_ff,
    output logic                    scl_hold_ff,
    output logic                    force_analog_inputs,
    output logic                    sequencer_pause,
    output logic                    cal_start_ff,
    output logic                    soft_reset_active
);
    import ssgc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ssgc_state_t          state_ff;
    ssgc_state_t          nxt_state;
    logic [2:0]           srst_cnt_ff;
    logic [NUM_FLAGS-1:0] flag_ff;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic                 fuse_ff;
    logic                 load_pend_ff;
    logic                 crc_en_ff;
    logic                 stats_ff;
    logic                 wcmp_ff;
    logic                 force_ff;
    logic                 cal_ff;
    logic                 wr_status;
    logic                 wr_gencfg;
    logic                 srst_done;
    logic [7:0]           status_view;
    logic [7:0]           gencfg_view;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign wr_status = reg_req.wr && (reg_req.addr == ADDR_SYSTEM_STATUS) && (state_ff == SSGC_IDLE);
    assign wr_gencfg = reg_req.wr && (reg_req.addr == ADDR_GENERAL_CONFIG) && (state_ff == SSGC_IDLE);
    assign srst_done = (state_ff == SSGC_DONE);

    // status and control writable except during soft reset; others blocked on checksum error or soft reset
    assign other_wr_allow = !flag_ff[1] && (state_ff == SSGC_IDLE);                  // R6

    // ----------------------------------------------------------------
    // software reset sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SSGC_IDLE: begin
                if (wr_gencfg && reg_req.wdata[GC_SRST]) begin                        // R15
                    nxt_state = SSGC_SRST;
                end
            end
            SSGC_SRST: begin
                if (srst_cnt_ff == SRST_LAST) begin
                    nxt_state = SSGC_DONE;
                end
            end
            SSGC_DONE: nxt_state = SSGC_IDLE;
            default:   nxt_state = SSGC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_ff <= SSGC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff != SSGC_SRST) begin
            srst_cnt_ff <= 3'h0;
        end else begin
            srst_cnt_ff <= srst_cnt_ff + 3'h1;
        end
    end

    assign soft_reset_active = (state_ff != SSGC_IDLE);                                // R15

    // ----------------------------------------------------------------
    // sticky flags, set wins over clear
    // ----------------------------------------------------------------
    assign flag_set[0] = evt.avg_ready;                                                // R3
    assign flag_set[1] = evt.crc_mismatch && crc_en_ff;                                // R5 R8
    assign flag_set[2] = evt.brownout || srst_done;                                    // R7 R15
    assign flag_clr[0] = wr_status && reg_req.wdata[ST_AVG];                           // R18
    assign flag_clr[1] = wr_status && reg_req.wdata[ST_CRCERR];
    assign flag_clr[2] = wr_status && reg_req.wdata[ST_BOR];

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            always_ff @(posedge sys_clk) begin
                if (!rst_b || state_ff == SSGC_SRST) begin
                    flag_ff[i] <= FLAG_RESET[i];
                end else if (flag_set[i]) begin
                    flag_ff[i] <= 1'b1;
                end else if (flag_clr[i]) begin
                    flag_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // configuration check capture at load and after software reset
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            load_pend_ff <= 1'b1;
            fuse_ff      <= 1'b0;
        end else if (load_pend_ff) begin
            load_pend_ff <= 1'b0;
            fuse_ff      <= cfg_check_fail;                                            // R4
        end else if (srst_done) begin
            fuse_ff      <= cfg_check_fail;                                            // R4
        end
    end

    // ----------------------------------------------------------------
    // general_config storage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff == SSGC_SRST) begin
            crc_en_ff <= GENCFG_RESET[GC_CRC_EN];
            stats_ff  <= GENCFG_RESET[GC_STATS];
            wcmp_ff   <= GENCFG_RESET[GC_WCMP];
            force_ff  <= GENCFG_RESET[GC_FORCE];
        end else if (wr_gencfg) begin
            crc_en_ff <= reg_req.wdata[GC_CRC_EN];                                     // R8
            stats_ff  <= reg_req.wdata[GC_STATS];                                      // R9
            wcmp_ff   <= reg_req.wdata[GC_WCMP];                                       // R10
            force_ff  <= reg_req.wdata[GC_FORCE];                                      // R13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || state_ff == SSGC_SRST) begin
            cal_ff <= GENCFG_RESET[GC_CAL];
        end else if (wr_gencfg && reg_req.wdata[GC_CAL]) begin
            cal_ff <= 1'b1;
        end else if (evt.cal_done) begin
            cal_ff <= 1'b0;                                                            // R14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cal_start_ff <= 1'b0;
        end else begin
            cal_start_ff <= wr_gencfg && reg_req.wdata[GC_CAL] && !cal_ff;             // R14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stats_clear_ff <= 1'b0;
        end else begin
            stats_clear_ff <= wr_gencfg && reg_req.wdata[GC_STATS] && !stats_ff;       // R9
        end
    end

    assign crc_enable               = crc_en_ff;                                       // R8
    assign stats_enable             = stats_ff;                                        // R9
    assign window_comparator_enable = wcmp_ff;                                         // R10
    assign window_comparator_reset  = !wcmp_ff;                                        // R10
    assign sequencer_pause          = continue_on_error && flag_ff[1];                 // R17
    assign force_analog_inputs      = force_ff || sequencer_pause;                     // R13 R17

    // ----------------------------------------------------------------
    // conversion start and clock stretch
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= evt.ninth_fall || (wr_gencfg && reg_req.wdata[GC_CONV]);  // R11 R12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            scl_hold_ff <= 1'b0;
        end else if (evt.ninth_fall) begin
            scl_hold_ff <= 1'b1;                                                       // R11
        end else if (evt.conv_done) begin
            scl_hold_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        status_view               = 8'h00;
        status_view[ST_FIXED_ONE] = 1'b1;                                              // R16
        status_view[ST_SEQ]       = evt.seq_running;                                   // R1
        status_view[ST_HS]        = evt.hs_mode;                                       // R2
        status_view[ST_AVG]       = flag_ff[0];
        status_view[ST_FUSE]      = fuse_ff;
        status_view[ST_CRCERR]    = flag_ff[1];
        status_view[ST_BOR]       = flag_ff[2];
        gencfg_view               = 8'h00;                                             // R12 R16
        gencfg_view[GC_CRC_EN]    = crc_en_ff;
        gencfg_view[GC_STATS]     = stats_ff;
        gencfg_view[GC_WCMP]      = wcmp_ff;
        gencfg_view[GC_FORCE]     = force_ff;
        gencfg_view[GC_CAL]       = cal_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_SYSTEM_STATUS:  reg_rdata_ff <= status_view;
                ADDR_GENERAL_CONFIG: reg_rdata_ff <= gencfg_view;
                default:             reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_seq_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_req.rd && reg_req.addr == ADDR_SYSTEM_STATUS) |=> reg_rdata_ff[6] == $past(evt.seq_running);
    endproperty
    a_seq_read: assert property (p_seq_read) else $error("sequencer bit wrong"); // R1

    property p_hs_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_req.rd && reg_req.addr == ADDR_SYSTEM_STATUS) |=> reg_rdata_ff[5] == $past(evt.hs_mode);
    endproperty
    a_hs_read: assert property (p_hs_read) else $error("speed bit wrong"); // R2

    property p_avg_set;
        @(posedge sys_clk) disable iff (!rst_b)
        (evt.avg_ready && state_ff != SSGC_SRST) |=> flag_ff[0];
    endproperty
    a_avg_set: assert property (p_avg_set) else $error("averaging flag not set"); // R3

    property p_fuse_stable;
        @(posedge sys_clk) disable iff (!rst_b)
        (!load_pend_ff && !srst_done) |=> $stable(fuse_ff);
    endproperty
    a_fuse_stable: assert property (p_fuse_stable) else $error("config check changed"); // R4

    property p_crc_block;
        @(posedge sys_clk) disable iff (!rst_b)
        flag_ff[1] |-> !other_wr_allow;
    endproperty
    a_crc_block: assert property (p_crc_block) else $error("write not blocked"); // R6

    property p_crc_gate;
        @(posedge sys_clk) disable iff (!rst_b)
        (!crc_en_ff && !flag_ff[1] && !wr_gencfg) |=> !flag_ff[1];
    endproperty
    a_crc_gate: assert property (p_crc_gate) else $error("error set while disabled"); // R8

    property p_bor_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (flag_clr[2] && !flag_set[2]) |=> !flag_ff[2];
    endproperty
    a_bor_clear: assert property (p_bor_clear) else $error("brown-out not cleared"); // R7

    property p_stretch;
        @(posedge sys_clk) disable iff (!rst_b)
        evt.ninth_fall |=> (scl_hold_ff && conv_start_ff);
    endproperty
    a_stretch: assert property (p_stretch) else $error("no stretch on ninth edge"); // R11

    property p_srst_bor;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_gencfg && reg_req.wdata[GC_SRST]) |=> ##[1:8] (flag_ff[2] && state_ff == SSGC_IDLE);
    endproperty
    a_srst_bor: assert property (p_srst_bor) else $error("software reset did not finish"); // R15

    property p_fixed;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_req.rd && reg_req.addr == ADDR_SYSTEM_STATUS) |=> (reg_rdata_ff[7] && !reg_rdata_ff[4]);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits wrong"); // R16

    property p_pause;
        @(posedge sys_clk) disable iff (!rst_b)
        (continue_on_error && flag_ff[1]) |-> (force_analog_inputs && sequencer_pause);
    endproperty
    a_pause: assert property (p_pause) else $error("error pause missing"); // R17

    property p_zero_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_status && reg_req.wdata == 8'h00 && flag_set == 3'h0) |=> $stable(flag_ff);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write changed flag"); // R18

    c_srst:  cover property (@(posedge sys_clk) disable iff (!rst_b) srst_done);
    c_block: cover property (@(posedge sys_clk) disable iff (!rst_b) flag_ff[1] && reg_req.wr);
    c_conv:  cover property (@(posedge sys_clk) disable iff (!rst_b) scl_hold_ff ##1 !scl_hold_ff);
    c_cal:   cover property (@(posedge sys_clk) disable iff (!rst_b) cal_ff ##1 !cal_ff);

endmodule

`default_nettype wire

// ==== test/ssgc_host_model.sv ====
// host side model: turns two-wire frames into byte register strobes
// assumes one access at a time, strobes launched just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module ssgc_host_model (
    input  wire logic                    sys_clk,
    input  wire logic [7:0]              rdata,
    output var  ssgc_pkg::ssgc_reg_req_t reg_req
);
    import ssgc_pkg::*;

    initial reg_req = '0;

    // ----------------------------------------------------------------
    // byte write, released bus shows inverted address and data
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // ----------------------------------------------------------------
    // byte read, data taken one cycle after the strobe edge
    // ----------------------------------------------------------------
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        @(posedge sys_clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ==== test/system_status_and_general_control_test.sv ====
// self-checking bench for the status and control register pair
// assumes the host model owns the register strobes, the bench owns events
`timescale 1ns/100ps
`default_nettype none
module system_status_and_general_control_test;
    import ssgc_pkg::*;
    logic          sys_clk;
    logic          rst_b;
    ssgc_reg_req_t reg_req;
    ssgc_evt_t     evt;
    logic          cfg_check_fail;
    logic          continue_on_error;
    logic [7:0]    rdata;
    logic          wr_allow, crc_en, st_en, st_clr, wc_en, wc_rst;
    logic          conv, hold, force_an, pause, cal, srst;
    logic [7:0]    d;
    int            error_cnt, checks_done, cyc, n_conv, n_cal, n_clr;

    ssgc_regs u_ssgc_regs (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req), .evt(evt),
        .cfg_check_fail(cfg_check_fail), .continue_on_error(continue_on_error), .reg_rdata_ff(rdata),
        .other_wr_allow(wr_allow), .crc_enable(crc_en), .stats_enable(st_en), .stats_clear_ff(st_clr),
        .window_comparator_enable(wc_en), .window_comparator_reset(wc_rst), .conv_start_ff(conv),
        .scl_hold_ff(hold), .force_analog_inputs(force_an), .sequencer_pause(pause),
        .cal_start_ff(cal), .soft_reset_active(srst));
    ssgc_host_model u_ssgc_host_model (.sys_clk(sys_clk), .rdata(rdata), .reg_req(reg_req));

    // ----------------------------------------------------------------
    // clock, pulse counters, hang guard
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_conv <= n_conv + int'(conv === 1'b1);
        n_cal  <= n_cal + int'(cal === 1'b1);
        n_clr  <= n_clr + int'(st_clr === 1'b1);
        cyc    <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input ssgc_evt_t m);
        @(posedge sys_clk);
        evt <= evt | m;
        @(posedge sys_clk);
        evt <= evt & ~m;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [7:0] outs();
        return {2'h0, hold, crc_en, st_en, wc_en, wc_rst, force_an};
    endfunction
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'h81);
        u_ssgc_host_model.rd(ADDR_GENERAL_CONFIG, d);
        chk(d, 8'h00);
        u_ssgc_host_model.rd(8'h02, d);
        chk(d, 8'h00);
    endtask
    task automatic t_flags();
        pulse('{crc_mismatch: 1'b1, default: 1'b0});
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'h81);
        u_ssgc_host_model.wr(ADDR_GENERAL_CONFIG, 8'h40);
        seq_lvl(1'b1);
        pulse('{avg_ready: 1'b1, crc_mismatch: 1'b1, brownout: 1'b1, default: 1'b0});
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'hEB);
        #1;
        chk({5'h0, wr_allow, pause, force_an}, 8'h03);
        u_ssgc_host_model.wr(ADDR_SYSTEM_STATUS, 8'h00);
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'hEB);
        u_ssgc_host_model.wr(ADDR_SYSTEM_STATUS, 8'hFF);
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'hE0);
        #1;
        chk({5'h0, wr_allow, pause, force_an}, 8'h04);
        seq_lvl(1'b0);
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'h80);
        pulse('{brownout: 1'b1, default: 1'b0});
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'h81);
    endtask
    task automatic seq_lvl(input logic v);
        @(posedge sys_clk);
        evt.seq_running <= v;
        evt.hs_mode     <= v;
    endtask
    task automatic t_control();
        u_ssgc_host_model.wr(ADDR_GENERAL_CONFIG, 8'hFE);
        u_ssgc_host_model.rd(ADDR_GENERAL_CONFIG, d);
        chk(d, 8'h76);
        chk(outs(), 8'h1D);
        chk(8'(n_conv), 8'h01);
        chk(8'(n_cal), 8'h01);
        chk(8'(n_clr), 8'h01);
        pulse('{cal_done: 1'b1, default: 1'b0});
        u_ssgc_host_model.rd(ADDR_GENERAL_CONFIG, d);
        chk(d, 8'h74);
        u_ssgc_host_model.wr(ADDR_GENERAL_CONFIG, 8'h00);
        wait_cyc(1);
        chk(outs(), 8'h02);
    endtask
    task automatic t_ninth();
        pulse('{ninth_fall: 1'b1, default: 1'b0});
        wait_cyc(5);
        chk(outs(), 8'h22);
        chk(8'(n_conv), 8'h02);
        pulse('{conv_done: 1'b1, default: 1'b0});
        wait_cyc(2);
        chk(outs(), 8'h02);
    endtask
    task automatic t_srst();
        int k;
        u_ssgc_host_model.wr(ADDR_GENERAL_CONFIG, 8'h75);
        wait_cyc(1);
        chk({7'h0, srst}, 8'h01);
        k = 0;
        while (srst !== 1'b0 && k < 12) begin
            wait_cyc(1);
            k++;
        end
        chk({7'h0, srst}, 8'h00);
        chk(8'(k), 8'(SRST_CYCLES_I));
        wait_cyc(2);
        u_ssgc_host_model.rd(ADDR_SYSTEM_STATUS, d);
        chk(d, 8'h85);
        u_ssgc_host_model.rd(ADDR_GENERAL_CONFIG, d);
        chk(d, 8'h00);
    endtask

    initial begin
        {error_cnt, checks_done, cyc, n_conv, n_cal, n_clr} = '0;
        rst_b             = 1'b0;
        evt               = '0;
        cfg_check_fail    = 1'b0;
        continue_on_error = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        cfg_check_fail    <= 1'b1;
        continue_on_error <= 1'b1;
        t_flags();
        t_control();
        t_ninth();
        t_srst();
        print_verdict();
    end
endmodule
`default_nettype wire
